// file: logic/ubc_pkg.sv
package ubc_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] UBC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] UBC_OFF_MODE   = 8'h04;
  localparam logic [7:0] UBC_OFF_DIV    = 8'h08;
  localparam logic [7:0] UBC_OFF_TXBUF  = 8'h0C;
  localparam logic [7:0] UBC_OFF_RXBUF  = 8'h10;
  localparam logic [7:0] UBC_OFF_STATUS = 8'h14;

  // CTRL field positions
  localparam int UBC_C_TXEN   = 0;
  localparam int UBC_C_RXEN   = 1;
  localparam int UBC_C_TXIRQS = 2;
  localparam int UBC_C_ERRON  = 3;
  localparam int UBC_C_AUTO_CLEAR_TX_ON_COLLISION   = 4;
  localparam int UBC_C_SAMP   = 5;
  localparam int UBC_C_EDGE   = 6;
  localparam int UBC_C_CLKSRC = 7;
  // MODE field positions
  localparam int UBC_M_SEL    = 0;
  localparam int UBC_M_STOP   = 3;
  localparam int UBC_M_PAR_ON = 4;
  localparam int UBC_M_PAR_OD = 5;
  localparam int UBC_M_MSB    = 6;
  localparam int UBC_M_INV    = 7;
  localparam int UBC_M_LPOL   = 8;
  // STATUS field positions; bits 0..5 clear by writing 1
  localparam int UBC_S_TXIRQ  = 0;
  localparam int UBC_S_RXIRQ  = 1;
  localparam int UBC_S_COLL   = 2;
  localparam int UBC_S_OVR    = 3;
  localparam int UBC_S_FRM    = 4;
  localparam int UBC_S_PAR    = 5;
  localparam int UBC_S_SUM    = 6;
  localparam int UBC_S_TXE    = 7;
  localparam int UBC_S_RXF    = 8;
  localparam int UBC_S_TSHE   = 9;

  localparam logic [31:0] UBC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] UBC_MODE_RST = 32'h0000_0000;
  localparam logic [7:0]  UBC_DIV_RST  = 8'h00;

  localparam logic [2:0] UBC_MODE_BUS = 3'h6;
  localparam logic [2:0] UBC_MODE_SIM = 3'h5;
  localparam logic [3:0] UBC_OVS      = 4'hF;   // 16 samples per bit, minus one
  localparam logic [3:0] UBC_OVS_MID  = 4'h7;

  localparam logic [1:0] UBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UBC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UBC_IDLE  = 2'b00,
    UBC_WAITE = 2'b01,
    UBC_SHIFT = 2'b10
  } ubc_tx_e;

  typedef enum logic [1:0] {
    UBC_R_IDLE = 2'b00,
    UBC_R_SHFT = 2'b01,
    UBC_R_ERRS = 2'b10
  } ubc_rx_e;

  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } ubc_axi_req_s;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ubc_axi_rsp_s;

endpackage

// file: logic/ubc_uart.sv
// What this block does
// RQ1 - One bus bit sent as one character
// RQ2 - Line mismatch raises collision request
// RQ3 - Software sets bus mode 110b, plain framing
// RQ4 - Collision sampled on clock or timer underflow
// RQ5 - Collision with auto clear drops transmit enable
// RQ6 - Start bit one bit period after conditions
// RQ7 - Edge start on receive line edge, polarity chosen
// RQ8 - Software arms transmit before the trigger edge
// RQ9 - Software routes shared collision interrupt first
// RQ10 - Smart-card parity error drives output low
// RQ11 - Bit rate is source over 16(n+1)
// RQ12 - Transmit only when enabled and buffer full
// RQ13 - Receive only when allowed and start seen
// RQ14 - Transmit done and receive load raise requests
// RQ15 - Overrun near last stop, no new request
// RQ16 - Framing, parity flags set at buffer load
// RQ17 - Error sum follows overrun, framing, parity
// RQ18 - Completion source plus error output raises request
// RQ19 - Buffer read clears parity, releases output
// RQ20 - Transmit done after stop bit's end
// RQ21 - Error signal only when output enabled
// RQ22 - Software picks smart-card direct or inverse format
// RQ23 - Inverse format inverts, MSB first, odd parity
// RQ24 - Bus character: start, nine data, stop
`timescale 1ns/1ps
`default_nettype none

module ubc_uart (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire ubc_pkg::ubc_axi_req_s axi_req,
  output var  ubc_pkg::ubc_axi_rsp_s axi_rsp,
  input  wire logic                  ext_clk,
  input  wire logic                  timer_underflow,
  input  wire logic                  serial_in_pin,
  output logic                       serial_out_pin,
  output logic                       serial_out_oe,
  output logic                       tx_irq,
  output logic                       rx_irq,
  output logic                       collision_irq
);
  import ubc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl;
  logic [31:0] mode;
  logic [7:0]  baud_divider;
  logic [8:0]  tx_buffer;
  logic [8:0]  rx_buffer;
  logic        tx_buffer_empty_flag;
  logic        rx_buffer_full_flag;
  logic        overrun_flag;
  logic        framing_error_flag;
  logic        parity_error_flag;
  logic        tx_pend;
  logic        rx_pend;
  logic        coll_pend;
  logic        tx_shift_empty;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        wr_go;
  logic        rd_go;
  logic        rx_read;
  logic [31:0] rd_val;
  logic        set_tx;
  logic        set_rx;
  logic        set_coll;
  logic        set_ovr;
  logic        set_frm;
  logic        set_par;
  logic        load_rx;
  logic [8:0]  rx_word;
  logic        clr_par;

  logic transmit_enable, rx_allow, tx_irq_source_select, error_signal_output_on;
  logic auto_clear_tx_on_collision, collision_sample_select, tx_start_on_line_edge;
  logic clock_source_select, stop_bit_count, parity_on, parity_odd_even_select;
  logic bit_order_select, data_logic_invert, line_polarity_invert;
  logic [2:0] serial_mode_select;
  logic bus_mode, sim_mode;

  assign transmit_enable            = ctrl[UBC_C_TXEN];
  assign rx_allow                   = ctrl[UBC_C_RXEN];
  assign tx_irq_source_select       = ctrl[UBC_C_TXIRQS];
  assign error_signal_output_on     = ctrl[UBC_C_ERRON];
  assign auto_clear_tx_on_collision = ctrl[UBC_C_AUTO_CLEAR_TX_ON_COLLISION];
  assign collision_sample_select    = ctrl[UBC_C_SAMP];
  assign tx_start_on_line_edge      = ctrl[UBC_C_EDGE];
  assign clock_source_select        = ctrl[UBC_C_CLKSRC];
  assign serial_mode_select         = mode[UBC_M_SEL +: 3];
  assign stop_bit_count             = mode[UBC_M_STOP];
  assign parity_on                  = mode[UBC_M_PAR_ON];
  assign parity_odd_even_select     = mode[UBC_M_PAR_OD];
  assign bit_order_select           = mode[UBC_M_MSB];
  assign data_logic_invert          = mode[UBC_M_INV];
  assign line_polarity_invert       = mode[UBC_M_LPOL];
  assign bus_mode = (serial_mode_select == UBC_MODE_BUS);
  assign sim_mode = (serial_mode_select == UBC_MODE_SIM);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by the second
  logic [1:0] rx_sy;
  logic [1:0] ck_sy;
  logic [1:0] tu_sy;
  logic       ck_d;
  logic       tu_d;
  logic       rx_d;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_sy <= 2'h3;
      ck_sy <= 2'h0;
      tu_sy <= 2'h0;
      ck_d  <= 1'b0;
      tu_d  <= 1'b0;
      rx_d  <= 1'b1;
    end else begin
      rx_sy <= {rx_sy[0], serial_in_pin};
      ck_sy <= {ck_sy[0], ext_clk};
      tu_sy <= {tu_sy[0], timer_underflow};
      ck_d  <= ck_sy[1];
      tu_d  <= tu_sy[1];
      rx_d  <= rx_sy[1];
    end
  end
  logic rx_line;
  assign rx_line = rx_sy[1] ^ line_polarity_invert;

  ////////////////////////////////////////////////////////////////////
  // Baud tick: source / (n+1), then 16 ticks per bit
  logic [7:0] bdiv;
  logic       src_tick;
  logic       os_tick;
  assign src_tick = clock_source_select ? (ck_sy[1] & ~ck_d) : 1'b1;
  always_ff @(posedge mclk) begin
    if (srst) begin
      bdiv <= UBC_DIV_RST;
    end else if (src_tick) begin
      bdiv <= (bdiv == 8'h00) ? baud_divider : bdiv - 8'h01;  // [RQ11]
    end
  end
  assign os_tick = src_tick && (bdiv == 8'h00);

  ////////////////////////////////////////////////////////////////////
  // Transmitter
  ubc_tx_e    tx_st;
  logic [3:0] tx_os;
  logic [3:0] tx_bit;
  logic [3:0] tx_last;
  logic [11:0] tx_sh;
  logic       tx_level;
  logic       tx_bit_end;
  logic       tx_mid;
  logic [7:0] tdat;
  logic       tpar;
  logic       edge_seen;
  // Bus mode: 9 data bits, no parity [RQ24]
  assign tx_last    = bus_mode ? 4'd10 : (4'd9 + {3'h0, parity_on} + {3'h0, stop_bit_count});
  assign tx_bit_end = os_tick && (tx_os == UBC_OVS);
  assign tx_mid     = os_tick && (tx_os == UBC_OVS_MID);
  assign edge_seen  = line_polarity_invert ? (rx_sy[1] & ~rx_d) : (~rx_sy[1] & rx_d);  // [RQ7]
  always_comb begin
    tdat = data_logic_invert ? ~tx_buffer[7:0] : tx_buffer[7:0];
    if (bit_order_select) begin
      for (int k = 0; k < 8; k++) tdat[k] = (data_logic_invert ? ~tx_buffer[7-k] : tx_buffer[7-k]);
    end
    tpar = (^tdat) ^ ~parity_odd_even_select;  // [RQ23]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_st    <= UBC_IDLE;
      tx_os    <= 4'h0;
      tx_bit   <= 4'h0;
      tx_sh    <= 12'hFFF;
      tx_level <= 1'b1;
      set_tx   <= 1'b0;
      tx_shift_empty <= 1'b1;
    end else begin
      set_tx <= 1'b0;
      case (tx_st)
        UBC_IDLE: begin
          tx_level <= 1'b1;
          if (transmit_enable && !tx_buffer_empty_flag) begin  // [RQ12]
            tx_st <= tx_start_on_line_edge ? UBC_WAITE : UBC_SHIFT;
            tx_os <= 4'h0;
            tx_bit <= 4'h0;
            tx_shift_empty <= 1'b0;
            if (bus_mode) tx_sh <= {2'b11, tx_buffer, 1'b0};  // [RQ1]
            else if (parity_on) tx_sh <= {2'b11, tpar, tdat, 1'b0};
            else tx_sh <= {3'b111, tdat, 1'b0};
          end
        end
        UBC_WAITE: begin
          tx_os <= 4'h0;
          if (!transmit_enable) tx_st <= UBC_IDLE;
          else if (edge_seen) begin  // [RQ7]
            tx_st <= UBC_SHIFT;
            tx_bit <= 4'h1;
            tx_level <= 1'b0;
          end
        end
        UBC_SHIFT: begin
          if (os_tick) tx_os <= tx_os + 4'h1;
          // Bit 0 is an idle bit period before start [RQ6]
          if (tx_bit_end) begin
            tx_level <= (tx_bit > tx_last) ? 1'b1 : tx_sh[tx_bit];
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_last + 4'h1) begin
              tx_st <= UBC_IDLE;
              tx_shift_empty <= 1'b1;
              set_tx <= 1'b1;  // [RQ14] [RQ20]
            end
          end
          if (bus_mode && auto_clear_tx_on_collision && coll_pend) begin
            tx_st <= UBC_IDLE;
            tx_level <= 1'b1;
            tx_shift_empty <= 1'b1;
          end
        end
        default: tx_st <= UBC_IDLE;
      endcase
    end
  end

  // Collision compare on each bit [RQ2] [RQ4] [RQ24]
  logic tx_line;
  assign tx_line = tx_level;
  always_comb begin
    set_coll = 1'b0;
    if (bus_mode && tx_st == UBC_SHIFT && tx_bit != 4'h0) begin
      if (collision_sample_select ? (tu_sy[1] & ~tu_d) : tx_mid)
        set_coll = (tx_line != rx_line);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver
  ubc_rx_e    rx_st;
  logic [3:0] rx_os;
  logic [3:0] rx_bit;
  logic [11:0] rx_sh;
  logic [3:0] rx_last;
  logic       err_drive;
  logic       ovr_seen;
  assign rx_last = tx_last;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_st <= UBC_R_IDLE;
      rx_os <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 12'h000;
      ovr_seen <= 1'b0;
    end else begin
      case (rx_st)
        UBC_R_IDLE: begin
          rx_os <= 4'h0;
          rx_bit <= 4'h0;
          ovr_seen <= 1'b0;
          if (rx_allow && !rx_line && !err_drive) rx_st <= UBC_R_SHFT;  // [RQ13]
        end
        UBC_R_SHFT: begin
          if (os_tick) rx_os <= rx_os + 4'h1;
          if (os_tick && rx_os == UBC_OVS_MID) begin
            rx_sh[rx_bit] <= rx_line;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_line) rx_st <= UBC_R_IDLE;
            if (rx_bit == rx_last - 4'h1 && rx_buffer_full_flag) ovr_seen <= 1'b1;  // [RQ15]
            if (rx_bit == rx_last) rx_st <= UBC_R_ERRS;
          end
        end
        UBC_R_ERRS: rx_st <= UBC_R_IDLE;
        default: rx_st <= UBC_R_IDLE;
      endcase
    end
  end

  // Character assembly and error checks at buffer load [RQ16]
  logic [7:0] rdat;
  logic       rpar_bad;
  always_comb begin
    rdat = rx_sh[8:1];
    if (bit_order_select) begin
      for (int k = 0; k < 8; k++) rdat[k] = rx_sh[8-k];
    end
    if (data_logic_invert) rdat = ~rdat;
    rx_word  = bus_mode ? rx_sh[9:1] : {1'b0, rdat};
    rpar_bad = parity_on && !bus_mode &&
               ((^rx_sh[9:1]) == parity_odd_even_select);  // [RQ23]
    load_rx  = (rx_st == UBC_R_ERRS);
    set_ovr  = load_rx && ovr_seen;
    set_rx   = load_rx && !ovr_seen;
    set_frm  = load_rx && !(rx_sh[rx_last] &&
               (!stop_bit_count || bus_mode || rx_sh[rx_last - 4'h1]));
    set_par  = load_rx && rpar_bad;
  end

  // Error signal low while parity error held [RQ10] [RQ21]
  assign err_drive = sim_mode && error_signal_output_on && parity_error_flag;
  assign serial_out_pin = err_drive ? 1'b0 : (tx_level ^ line_polarity_invert);
  // Smart-card output is open drain: driven only for a low transmit level or the error signal
  assign serial_out_oe  = sim_mode ? (err_drive || !tx_level) : 1'b1;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; both halves held, then one write
  assign wr_go   = aw_hold && w_hold && !axi_rsp.bvalid;
  assign rd_go   = axi_req.arvalid && axi_rsp.arready;
  assign rx_read = rd_go && (axi_req.araddr == UBC_OFF_RXBUF);
  assign clr_par = rx_read;  // [RQ19]
  logic        b_vld;
  logic        r_vld;
  logic [1:0]  b_rsp;
  logic [1:0]  r_rsp;
  logic [31:0] r_dat;
  assign axi_rsp = '{awready: !aw_hold && !b_vld, wready: !w_hold && !b_vld,
                     bvalid: b_vld, bresp: b_rsp, arready: !r_vld, rvalid: r_vld,
                     rdata: r_dat, rresp: r_rsp};

  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      b_vld <= 1'b0;
      b_rsp <= UBC_RESP_OKAY;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_hold <= 1'b1;
        aw_addr <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_hold <= 1'b1;
        w_data <= axi_req.wdata;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        b_vld <= 1'b1;
        b_rsp <= (aw_addr > UBC_OFF_STATUS || aw_addr[1:0] != 2'h0) ?
                 UBC_RESP_SLVERR : UBC_RESP_OKAY;
      end else if (axi_req.bready) begin
        b_vld <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (axi_req.araddr)
      UBC_OFF_CTRL:   rd_val = ctrl;
      UBC_OFF_MODE:   rd_val = mode;
      UBC_OFF_DIV:    rd_val = {24'h0, baud_divider};
      UBC_OFF_TXBUF:  rd_val = {23'h0, tx_buffer};
      UBC_OFF_RXBUF:  rd_val = {23'h0, rx_buffer};
      UBC_OFF_STATUS: rd_val = {22'h0, tx_shift_empty, rx_buffer_full_flag,
                                tx_buffer_empty_flag,
                                overrun_flag | framing_error_flag | parity_error_flag,  // [RQ17]
                                parity_error_flag, framing_error_flag, overrun_flag,
                                coll_pend, rx_pend, tx_pend};
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r_vld <= 1'b0;
      r_dat <= 32'h0000_0000;
      r_rsp <= UBC_RESP_OKAY;
    end else if (rd_go) begin
      r_vld <= 1'b1;
      r_dat <= rd_val;
      r_rsp <= (axi_req.araddr > UBC_OFF_STATUS || axi_req.araddr[1:0] != 2'h0) ?
               UBC_RESP_SLVERR : UBC_RESP_OKAY;
    end else if (axi_req.rready) begin
      r_vld <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers and flags; hardware set wins over software clear, except that a TXBUF write wins over setting the transmit empty flag
  logic wr_ctrl, wr_mode, wr_stat, wr_tx;
  logic [31:0] w1c;
  assign wr_ctrl = wr_go && aw_addr == UBC_OFF_CTRL;
  assign wr_mode = wr_go && aw_addr == UBC_OFF_MODE;
  assign wr_stat = wr_go && aw_addr == UBC_OFF_STATUS;
  assign wr_tx   = wr_go && aw_addr == UBC_OFF_TXBUF;
  assign w1c     = wr_stat ? w_data : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= UBC_CTRL_RST;
      mode <= UBC_MODE_RST;
      baud_divider <= UBC_DIV_RST;
      tx_buffer <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
    end else begin
      if (wr_ctrl) ctrl <= w_data;
      if (set_coll && auto_clear_tx_on_collision) ctrl[UBC_C_TXEN] <= 1'b0;  // [RQ5]
      if (wr_mode) mode <= w_data;
      if (wr_go && aw_addr == UBC_OFF_DIV) baud_divider <= w_data[7:0];
      if (wr_tx) begin
        tx_buffer <= w_data[8:0];
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_st == UBC_IDLE && transmit_enable && !tx_buffer_empty_flag) begin
        tx_buffer_empty_flag <= 1'b1;
      end
    end
  end

  // Completion source with error output on after reset requests [RQ18]
  logic arm_done;
  always_ff @(posedge mclk) begin
    if (srst) begin
      arm_done <= 1'b0;
      tx_pend <= 1'b0;
      rx_pend <= 1'b0;
      coll_pend <= 1'b0;
      overrun_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      rx_buffer <= 9'h000;
      rx_buffer_full_flag <= 1'b0;
    end else begin
      if (tx_irq_source_select && error_signal_output_on) arm_done <= 1'b1;
      tx_pend   <= (set_tx || (!arm_done && tx_irq_source_select && error_signal_output_on))
                   || (tx_pend && !w1c[UBC_S_TXIRQ]);
      rx_pend   <= set_rx || (rx_pend && !w1c[UBC_S_RXIRQ]);
      coll_pend <= set_coll || (coll_pend && !w1c[UBC_S_COLL]);
      overrun_flag       <= set_ovr || (overrun_flag && !w1c[UBC_S_OVR]);
      framing_error_flag <= set_frm || (framing_error_flag && !w1c[UBC_S_FRM]);
      parity_error_flag  <= set_par || (parity_error_flag && !w1c[UBC_S_PAR] && !clr_par);
      if (set_rx) rx_buffer <= rx_word;
      rx_buffer_full_flag <= load_rx || (rx_buffer_full_flag && !rx_read);
    end
  end

  assign tx_irq        = tx_pend;
  assign rx_irq        = rx_pend;
  assign collision_irq = coll_pend;

endmodule

`default_nettype wire

// file: bench/ubc_uart_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ubc_uart_chk (
  input wire logic                  mclk,
  input wire logic                  srst,
  input wire ubc_pkg::ubc_axi_req_s axi_req,
  input wire ubc_pkg::ubc_axi_rsp_s axi_rsp,
  input wire logic                  ext_clk,
  input wire logic                  timer_underflow,
  input wire logic                  serial_in_pin,
  input wire logic                  serial_out_pin,
  input wire logic                  serial_out_oe,
  input wire logic                  tx_irq,
  input wire logic                  rx_irq,
  input wire logic                  collision_irq
);
  import ubc_pkg::*;
  logic [3:0] since_mis;
  ////////////////////////////////////////
  // Saturating age of the last pin mismatch
  always_ff @(posedge mclk) begin
    if (srst)
      since_mis <= 4'hF;
    else if (serial_out_pin != serial_in_pin)
      since_mis <= 4'h0;
    else if (since_mis != 4'hF)
      since_mis <= since_mis + 4'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  AST_RESET_IDLE: assert property (disable iff (1'b0) srst |=> serial_out_pin && !tx_irq
    && !rx_irq && !collision_irq && !axi_rsp.bvalid && !axi_rsp.rvalid)
    else $error("outputs not idle after reset");
  AST_WRITE_RESP: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write response late");
  AST_READ_RESP: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late");
  AST_LOW_DRIVEN: assert property (!serial_out_pin |-> serial_out_oe)
    else $error("low level not driven");
  AST_START_LEN: assert property ($fell(serial_out_pin) |-> !serial_out_pin [*8])
    else $error("low pulse too short");
  AST_COLL_CAUSE: assert property ($rose(collision_irq) |-> since_mis < 4'hC)
    else $error("collision without pin mismatch");
  AST_TX_DONE_IDLE: assert property ($rose(tx_irq) |-> serial_out_pin)
    else $error("transmit done while line low");
  AST_RX_CLEAR: assert property ($fell(rx_irq) |-> $past(axi_req.wvalid)
    || $past(axi_req.wvalid, 2) || $past(axi_req.wvalid, 3))
    else $error("receive request lost without write");
endmodule
`default_nettype wire

// file: bench/ubc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ubc_line_model (
  input  wire logic mclk,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe,
  output logic      line
);
  logic drv = 1'b1;
  // Wired-AND with pull-up; released line reads high
  assign line = (serial_out_oe ? serial_out_pin : 1'b1) & drv;
  task automatic send(input logic [8:0] v);
    int i;
    @(posedge mclk);
    for (i = 0; i < 11; i++) begin
      drv <= (i == 0) ? 1'b0 : ((i == 10) ? 1'b1 : v[i-1]);
      repeat (16) @(posedge mclk);
    end
  endtask
  task automatic pull(input int n);
    @(posedge mclk);
    drv <= 1'b0;
    repeat (n) @(posedge mclk);
    drv <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: bench/ubc_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITF(c, n) for (k = 0; k < (n) && !(c); k++) @(negedge mclk);
module ubc_uart_tb;
  import ubc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} ubc_row_s;
  typedef struct packed {logic [8:0] m; logic [7:0] c; logic [8:0] v; logic lo; logic pe;} ubc_sim_s;
  logic         mclk = 1'b0;
  logic         srst = 1'b1;
  logic         ext_clk = 1'b0;
  logic         tmr = 1'b0;
  ubc_axi_req_s q = '0;
  ubc_axi_rsp_s p;
  logic         sin, serial_out_pin, serial_out_oe, tx_irq, rx_irq, collision_irq, lo;
  logic [31:0]  rdat;
  logic [1:0]   resp;
  int           k, b, n_fail = 0, samples_checked = 0;
  ubc_row_s rows [4] = '{'{UBC_OFF_CTRL, 32'hC0, 32'hC0, UBC_RESP_OKAY},
    '{UBC_OFF_MODE, 32'h1FF, 32'h1FF, UBC_RESP_OKAY},
    '{UBC_OFF_DIV, 32'h1AB, 32'hAB, UBC_RESP_OKAY}, '{8'h18, 32'h1, 32'h0, UBC_RESP_SLVERR}};
  ubc_sim_s sims [4] = '{'{9'h035, 8'h0E, 9'h15A, 1'b1, 1'b1},
    '{9'h035, 8'h06, 9'h15A, 1'b0, 1'b1}, '{9'h035, 8'h0E, 9'h05A, 1'b0, 1'b0},
    '{9'h0D5, 8'h0E, 9'h1A5, 1'b0, 1'b0}};
  always #5 mclk = ~mclk;
  always #20 ext_clk = ~ext_clk;
  ubc_uart dut_u (.mclk(mclk), .srst(srst), .axi_req(q), .axi_rsp(p), .ext_clk(ext_clk),
    .timer_underflow(tmr), .serial_in_pin(sin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .collision_irq(collision_irq));
  ubc_line_model u_m (.mclk(mclk), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .line(sin));
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    q.awvalid <= 1'b1;
    q.awaddr <= a;
    q.wvalid <= 1'b1;
    q.wdata <= d;
    q.wstrb <= 4'hF;
    q.bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge mclk);
      ad = ad | (q.awvalid & p.awready);
      wd = wd | (q.wvalid & p.wready);
      @(posedge mclk);
      if (ad) q.awvalid <= 1'b0;
      if (wd) q.wvalid <= 1'b0;
    end
    do @(negedge mclk); while (p.bvalid !== 1'b1);
    resp = p.bresp;
    @(posedge mclk);
    q.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    q.arvalid <= 1'b1;
    q.araddr <= a;
    q.rready <= 1'b1;
    do @(negedge mclk); while (p.arready !== 1'b1);
    @(posedge mclk);
    q.arvalid <= 1'b0;
    do @(negedge mclk); while (p.rvalid !== 1'b1);
    rdat = p.rdata;
    resp = p.rresp;
    @(posedge mclk);
    q.rready <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK(resp, rows[i].r)
      rd(rows[i].a);
      `CHK(resp, rows[i].r)
      if (rows[i].r == UBC_RESP_OKAY) `CHK(rdat, rows[i].x)
    end
    $display("test registers done");
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(rows[i].a);
      `CHK(rdat, 32'h0)
    end
    rd(UBC_OFF_STATUS);
    `CHK(rdat[9:0], 10'h280)
    $display("test reset done");
    // Loopback frames: internal clock at two dividers, then external clock
    for (int i = 0; i < 3; i++) begin
      b = (i == 1) ? 48 : 16;
      wr(UBC_OFF_DIV, (i == 1) ? 32'h2 : 32'h0);
      wr(UBC_OFF_MODE, {29'h0, UBC_MODE_BUS});
      wr(UBC_OFF_CTRL, (i == 2) ? 32'h83 : 32'h03);
      wr(UBC_OFF_TXBUF, 32'h1A5);
      `WAITF(!serial_out_pin, 3000)
      if (i < 2) `CHK(k + 4 >= b && k <= b + 2, 1'b1)
      `WAITF(serial_out_pin, 3000)
      if (i < 2) `CHK(k, b)
      `WAITF(rx_irq && tx_irq, 3000)
      `CHK(tx_irq, 1'b1)
      `CHK(collision_irq, 1'b0)
      rd(UBC_OFF_RXBUF);
      `CHK(rdat[8:0], 9'h1A5)
      wr(UBC_OFF_STATUS, 32'h3F);
      `CHK(tx_irq, 1'b0)
    end
    $display("test loopback done");
    for (int s = 0; s < 2; s++) begin
      wr(UBC_OFF_CTRL, s ? 32'h33 : 32'h13);
      wr(UBC_OFF_TXBUF, 32'h1FF);
      `WAITF(!serial_out_pin, 600)
      fork
        u_m.pull(60);
        begin
          repeat (40) @(negedge mclk);
          if (s) begin
            `CHK(collision_irq, 1'b0)
            @(posedge mclk);
            tmr <= 1'b1;
            repeat (3) @(posedge mclk);
            tmr <= 1'b0;
          end
        end
      join
      `CHK(collision_irq, 1'b1)
      rd(UBC_OFF_CTRL);
      `CHK(rdat[UBC_C_TXEN], 1'b0)
      repeat (300) @(negedge mclk);
      rd(UBC_OFF_RXBUF);
      wr(UBC_OFF_STATUS, 32'h3F);
    end
    $display("test collision done");
    // Data is loaded before the trigger edge arrives
    wr(UBC_OFF_CTRL, 32'h41);
    wr(UBC_OFF_TXBUF, 32'h1A5);
    repeat (100) @(negedge mclk);
    `CHK(serial_out_pin, 1'b1)
    u_m.pull(4);
    `WAITF(!serial_out_pin, 40)
    `CHK(serial_out_pin, 1'b0)
    `WAITF(tx_irq, 400)
    `CHK(tx_irq, 1'b1)
    `CHK(rx_irq, 1'b0)
    wr(UBC_OFF_CTRL, 32'h0);
    wr(UBC_OFF_STATUS, 32'h3F);
    $display("test edge start done");
    wr(UBC_OFF_MODE, 32'h35);
    wr(UBC_OFF_CTRL, 32'h0E);
    repeat (4) @(negedge mclk);
    `CHK(tx_irq, 1'b1)
    wr(UBC_OFF_STATUS, 32'h3F);
    foreach (sims[i]) begin
      wr(UBC_OFF_MODE, {23'h0, sims[i].m});
      wr(UBC_OFF_CTRL, {24'h0, sims[i].c});
      lo = 1'b0;
      fork
        u_m.send(sims[i].v);
        for (int j = 0; j < 220; j++) begin
          @(negedge mclk);
          if (!serial_out_pin) lo = 1'b1;
        end
      join
      `CHK(lo, sims[i].lo)
      rd(UBC_OFF_STATUS);
      `CHK(rdat[UBC_S_PAR], sims[i].pe)
      `CHK(rdat[UBC_S_SUM], sims[i].pe)
      rd(UBC_OFF_RXBUF);
      `CHK(rdat[7:0], 8'h5A)
      `CHK(serial_out_pin, 1'b1)
      rd(UBC_OFF_STATUS);
      `CHK(rdat[UBC_S_PAR], 1'b0)
      wr(UBC_OFF_STATUS, 32'h3F);
    end
    u_m.send(9'h1A5);
    u_m.send(9'h1A5);
    repeat (20) @(negedge mclk);
    rd(UBC_OFF_STATUS);
    `CHK(rdat[UBC_S_OVR], 1'b1)
    `CHK(rdat[UBC_S_SUM], 1'b1)
    $display("test smart card done");
    final_report();
  end
  // Whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    final_report();
  end
endmodule
bind ubc_uart ubc_uart_chk u_chk (.mclk(mclk), .srst(srst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .ext_clk(ext_clk), .timer_underflow(timer_underflow),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .tx_irq(tx_irq), .rx_irq(rx_irq),
  .collision_irq(collision_irq));
`default_nettype wire
